//--- logic/dcsl_pkg.sv
package dcsl_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    // control fields
    localparam int CTRL_INVERT = 0;
    localparam int CTRL_REARM = 1;
    localparam int CTRL_ANALOG = 2;
    localparam int CTRL_REMOTE = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // command fields (write pulses)
    localparam int CMD_ON = 0;
    localparam int CMD_OFF = 1;
    // status fields
    localparam int STAT_OUT = 0;
    localparam int STAT_LOCK = 1;
    localparam int STAT_PEND = 2;
    localparam int STAT_PIN = 3;
    localparam int STAT_ARMED = 4;
    // interrupt events
    localparam int EV_REJECT = 0;
    localparam int EV_PIN_OFF = 1;
    localparam int EV_PIN_ON = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        DCSL_OFF_IDLE = 2'b00,
        DCSL_ON = 2'b01,
        DCSL_OFF_PEND = 2'b11
    } dcsl_state_t;
endpackage

//--- logic/dcsl_sync.sv
`timescale 1ns/1ns
module dcsl_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout,
    output logic rise,
    output logic fall
);
    logic [dcsl_pkg::SYNC_STAGES-1:0] sync_q;
    logic last_q;
    // pin idles high, so reset to high to avoid a false edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync_q <= '1;
            last_q <= 1'b1;
        end else begin
            sync_q <= {sync_q[0], din};
            last_q <= sync_q[1];
        end
    end
    assign dout = sync_q[1];
    assign rise = sync_q[1] & ~last_q;
    assign fall = ~sync_q[1] & last_q;
endmodule

//--- logic/dcsl_wb.sv
`timescale 1ns/1ns
module dcsl_wb (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] rd_data,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wr_stb,
    output logic [7:0] wr_adr,
    output logic [7:0] wr_data
);
    logic req;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // one wait state: ack one cycle after request, dropped next cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req && !wb_we_i ? rd_data : 32'h0000_0000;
        end
    end
    // only the low byte lane carries fields; write lands on the ack edge, while the master still holds it
    assign wr_stb = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign wr_adr = wb_adr_i;
    assign wr_data = wb_dat_i[7:0];
endmodule

//--- logic/dcsl_top.sv
`timescale 1ns/1ns
// Overview of operation
// - first switch-on after reset only from button or command, never pin.
// - rearm setting picks pin off-only or pin off-and-on.
// - pin-driven switch-on only while remote mode is active.
// - lock level blocks switch-on in manual and remote mode.
// - analog remote mode: output follows effective pin level alone.
// - polarity setting normal or inverted reverses pin meaning.
// - open pin reads high; high with normal polarity means on.
// - entering analog remote with pin at on level switches on at once.
// - manual, off, pin at non-lock level: unlocked, button or command may turn on.
// - manual, off, pin at lock level: refuse button and command switch-on.
// - switch-on request while locked is rejected and flagged.
// - on and pin not at lock level: stays on, button or command work.
// - on and pin goes to lock level: switch off and hold locked.
// - after pin switch-off, pin toggling back switches on again.
// - off action during lock clears the pending pin switch-on.
module dcsl_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic output_standby_pin,
    input wire logic button_press,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic dc_output_on,
    output logic dc_locked,
    output logic reject_error,
    output logic irq
);
    logic pin_s, pin_rise, pin_fall;
    logic wr_stb;
    logic [7:0] wr_adr, wr_data;
    logic [31:0] rd_data;
    logic [3:0] ctrl_q;
    logic [dcsl_pkg::EV_W-1:0] irq_stat_q, irq_en_q, ev;
    logic armed_q, analog_q, cmd_on, cmd_off, req_on, req_off;
    logic pin_on_lvl, lock_lvl, go_lock, go_unlock, analog_entry;
    dcsl_pkg::dcsl_state_t state_q, state_d;

    dcsl_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din(output_standby_pin),
        .dout(pin_s),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    dcsl_wb u_wb (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .rd_data(rd_data),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wr_stb(wr_stb),
        .wr_adr(wr_adr),
        .wr_data(wr_data)
    );

    // effective level: invert flips meaning, open pin is high
    assign pin_on_lvl = ctrl_q[dcsl_pkg::CTRL_INVERT] ? ~pin_s : pin_s;
    assign lock_lvl = ~pin_on_lvl;
    // a toggle into or out of the lock level, after polarity
    assign go_lock = ctrl_q[dcsl_pkg::CTRL_INVERT] ? pin_rise : pin_fall;
    assign go_unlock = ctrl_q[dcsl_pkg::CTRL_INVERT] ? pin_fall : pin_rise;

    assign cmd_on = wr_stb && wr_adr == dcsl_pkg::ADDR_CMD && wr_data[dcsl_pkg::CMD_ON];
    assign cmd_off = wr_stb && wr_adr == dcsl_pkg::ADDR_CMD && wr_data[dcsl_pkg::CMD_OFF];
    // button toggles; command off beats command on in the same write
    assign req_off = cmd_off | (button_press & state_q == dcsl_pkg::DCSL_ON);
    assign req_on = ~req_off & (cmd_on | (button_press & state_q != dcsl_pkg::DCSL_ON));
    assign analog_entry = ctrl_q[dcsl_pkg::CTRL_ANALOG] & ~analog_q;

    // control register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= dcsl_pkg::CTRL_RESET;
        end else if (wr_stb && wr_adr == dcsl_pkg::ADDR_CTRL) begin
            ctrl_q <= wr_data[3:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            analog_q <= 1'b0;
        end else begin
            analog_q <= ctrl_q[dcsl_pkg::CTRL_ANALOG];
        end
    end

    // pin may not do the very first switch-on after reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (state_q == dcsl_pkg::DCSL_ON) begin
            armed_q <= 1'b1;
        end
    end

    // output state machine
    always_comb begin
        state_d = state_q;
        ev = dcsl_pkg::EV_RESET;
        if (ctrl_q[dcsl_pkg::CTRL_ANALOG] && armed_q) begin
            // analog remote: pin level alone decides
            state_d = pin_on_lvl ? dcsl_pkg::DCSL_ON : dcsl_pkg::DCSL_OFF_IDLE;
            ev[dcsl_pkg::EV_PIN_ON] = pin_on_lvl && state_q != dcsl_pkg::DCSL_ON;
            ev[dcsl_pkg::EV_PIN_OFF] = !pin_on_lvl && state_q == dcsl_pkg::DCSL_ON;
            ev[dcsl_pkg::EV_REJECT] = req_on & lock_lvl;
        end else begin
            case (state_q)
                dcsl_pkg::DCSL_ON: begin
                    if (lock_lvl) begin
                        state_d = dcsl_pkg::DCSL_OFF_PEND;
                        ev[dcsl_pkg::EV_PIN_OFF] = 1'b1;
                    end else if (req_off) begin
                        state_d = dcsl_pkg::DCSL_OFF_IDLE;
                    end
                end
                dcsl_pkg::DCSL_OFF_PEND: begin
                    if (req_off) begin
                        state_d = dcsl_pkg::DCSL_OFF_IDLE;
                    end else if (go_unlock && ctrl_q[dcsl_pkg::CTRL_REARM]
                                 && ctrl_q[dcsl_pkg::CTRL_REMOTE]) begin
                        state_d = dcsl_pkg::DCSL_ON;
                        ev[dcsl_pkg::EV_PIN_ON] = 1'b1;
                    end else if (req_on && lock_lvl) begin
                        ev[dcsl_pkg::EV_REJECT] = 1'b1;
                    end else if (req_on) begin
                        // pin back at free level without rearm: no longer locked
                        state_d = dcsl_pkg::DCSL_ON;
                    end
                end
                default: begin
                    if (req_on && lock_lvl) begin
                        ev[dcsl_pkg::EV_REJECT] = 1'b1;
                    end else if (req_on) begin
                        state_d = dcsl_pkg::DCSL_ON;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= dcsl_pkg::DCSL_OFF_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from flip-flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dc_output_on <= 1'b0;
            dc_locked <= 1'b0;
            reject_error <= 1'b0;
        end else begin
            dc_output_on <= state_d == dcsl_pkg::DCSL_ON;
            dc_locked <= state_d != dcsl_pkg::DCSL_ON && lock_lvl;
            reject_error <= ev[dcsl_pkg::EV_REJECT];
        end
    end

    // sticky events: a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_stat_q <= dcsl_pkg::EV_RESET;
        end else if (wr_stb && wr_adr == dcsl_pkg::ADDR_IRQ_CLR) begin
            irq_stat_q <= (irq_stat_q & ~wr_data[dcsl_pkg::EV_W-1:0]) | ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_en_q <= dcsl_pkg::EV_RESET;
        end else if (wr_stb && wr_adr == dcsl_pkg::ADDR_IRQ_EN) begin
            irq_en_q <= wr_data[dcsl_pkg::EV_W-1:0];
        end
    end

    // level irq; lags status by one cycle to come from a flip-flop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // read mux; unmapped and write-only addresses read zero
    always_comb begin
        if (wb_adr_i == dcsl_pkg::ADDR_CTRL) begin
            rd_data = {28'h0000000, ctrl_q};
        end else if (wb_adr_i == dcsl_pkg::ADDR_STAT) begin
            rd_data = {27'h0000000, armed_q, pin_s, state_q == dcsl_pkg::DCSL_OFF_PEND,
                       dc_locked, dc_output_on};
        end else if (wb_adr_i == dcsl_pkg::ADDR_IRQ_STAT) begin
            rd_data = {29'h00000000, irq_stat_q};
        end else if (wb_adr_i == dcsl_pkg::ADDR_IRQ_EN) begin
            rd_data = {29'h00000000, irq_en_q};
        end else begin
            rd_data = 32'h0000_0000;
        end
    end

    // assertions
    property p_first_on;
        @(posedge ref_clk) disable iff (!rst_n)
        !armed_q && state_q != dcsl_pkg::DCSL_ON && !cmd_on && !button_press |=> !dc_output_on;
    endproperty
    a_first_on: assert property (p_first_on) else $error("pin made first switch-on");

    property p_lock_off;
        @(posedge ref_clk) disable iff (!rst_n)
        state_q == dcsl_pkg::DCSL_ON && lock_lvl |=> !dc_output_on ##0 dc_locked;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock level did not switch off");

    property p_reject;
        @(posedge ref_clk) disable iff (!rst_n)
        state_q != dcsl_pkg::DCSL_ON && lock_lvl && req_on && !analog_entry |=> reject_error && !dc_output_on;
    endproperty
    a_reject: assert property (p_reject) else $error("locked switch-on not rejected");

    property p_unlocked_on;
        @(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[dcsl_pkg::CTRL_ANALOG] && state_q == dcsl_pkg::DCSL_OFF_IDLE && pin_on_lvl && req_on
        |=> dc_output_on;
    endproperty
    a_unlocked_on: assert property (p_unlocked_on) else $error("unlocked switch-on refused");

    property p_no_remote;
        @(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[dcsl_pkg::CTRL_REMOTE] && !ctrl_q[dcsl_pkg::CTRL_ANALOG] && !dc_output_on && !req_on
        |=> !dc_output_on;
    endproperty
    a_no_remote: assert property (p_no_remote) else $error("pin switched on outside remote");

    property p_analog;
        @(posedge ref_clk) disable iff (!rst_n)
        ctrl_q[dcsl_pkg::CTRL_ANALOG] && armed_q |=> dc_output_on == $past(pin_on_lvl);
    endproperty
    a_analog: assert property (p_analog) else $error("analog mode not following pin");

    property p_clear_pend;
        @(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[dcsl_pkg::CTRL_ANALOG] && state_q == dcsl_pkg::DCSL_OFF_PEND && req_off
        |=> state_q == dcsl_pkg::DCSL_OFF_IDLE;
    endproperty
    a_clear_pend: assert property (p_clear_pend) else $error("off did not clear pending");

    property p_rearm;
        @(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[dcsl_pkg::CTRL_ANALOG] && state_q == dcsl_pkg::DCSL_OFF_PEND && go_unlock && !req_off
        && ctrl_q[dcsl_pkg::CTRL_REARM] && ctrl_q[dcsl_pkg::CTRL_REMOTE] |=> dc_output_on;
    endproperty
    a_rearm: assert property (p_rearm) else $error("pin toggle did not re-enable");

    property p_sync;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(pin_s) |-> $past(output_standby_pin, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser depth wrong");

    property p_lock_blocks;
        @(posedge ref_clk) disable iff (!rst_n)
        state_q != dcsl_pkg::DCSL_ON && lock_lvl |=> !dc_output_on;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("switch-on at lock level");

    property p_entry_on;
        @(posedge ref_clk) disable iff (!rst_n)
        analog_entry && armed_q && pin_on_lvl |=> dc_output_on;
    endproperty
    a_entry_on: assert property (p_entry_on) else $error("analog entry did not switch on");

    property p_inv_locks;
        @(posedge ref_clk) disable iff (!rst_n)
        ctrl_q[dcsl_pkg::CTRL_INVERT] && pin_s && state_q != dcsl_pkg::DCSL_ON |=> dc_locked;
    endproperty
    a_inv_locks: assert property (p_inv_locks) else $error("inverted high did not lock");

    property p_open_free;
        @(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[dcsl_pkg::CTRL_INVERT] && pin_s |=> !dc_locked;
    endproperty
    a_open_free: assert property (p_open_free) else $error("open pin locked output");

    property p_reject_cause;
        @(posedge ref_clk) disable iff (!rst_n)
        reject_error |-> $past(lock_lvl);
    endproperty
    a_reject_cause: assert property (p_reject_cause) else $error("reject without lock level");

    property p_on_stays;
        @(posedge ref_clk) disable iff (!rst_n)
        state_q == dcsl_pkg::DCSL_ON && !lock_lvl && !req_off |=> dc_output_on;
    endproperty
    a_on_stays: assert property (p_on_stays) else $error("output dropped without cause");

    property p_off_cmd;
        @(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[dcsl_pkg::CTRL_ANALOG] && state_q == dcsl_pkg::DCSL_ON && !lock_lvl && req_off |=> !dc_output_on;
    endproperty
    a_off_cmd: assert property (p_off_cmd) else $error("off request ignored");

    property p_no_rearm;
        @(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[dcsl_pkg::CTRL_ANALOG] && state_q == dcsl_pkg::DCSL_OFF_PEND && !ctrl_q[dcsl_pkg::CTRL_REARM]
        && !req_on |=> !dc_output_on;
    endproperty
    a_no_rearm: assert property (p_no_rearm) else $error("pin re-enabled without rearm");

    property p_pin_off_ev;
        @(posedge ref_clk) disable iff (!rst_n)
        state_q == dcsl_pkg::DCSL_ON && lock_lvl |=> irq_stat_q[dcsl_pkg::EV_PIN_OFF];
    endproperty
    a_pin_off_ev: assert property (p_pin_off_ev) else $error("pin switch-off not flagged");

    property p_ack;
        @(posedge ref_clk) disable iff (!rst_n)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus request not acknowledged");

    c_reject: cover property (@(posedge ref_clk) disable iff (!rst_n) reject_error);
    c_pin_off: cover property (@(posedge ref_clk) disable iff (!rst_n) state_q == dcsl_pkg::DCSL_OFF_PEND);
    c_rearm: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == dcsl_pkg::DCSL_OFF_PEND ##1 state_q == dcsl_pkg::DCSL_ON);
    c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) irq);
    c_analog: cover property (@(posedge ref_clk) disable iff (!rst_n) analog_entry && armed_q);
endmodule

//--- tb/dcsl_contact.sv
`timescale 1ns/1ns
// external contact to logic_ground with the pin's pull-up behind it
module dcsl_contact (
    input wire logic closed,
    output logic pin
);
    // open contact leaves the pull-up in charge, never a held old level
    always_comb begin
        pin = closed ? 1'b0 : 1'b1;
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic closed = 1'b0;
    logic btn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic pin, ack, on, locked, rej, irq;
    int rej_cnt = 0;
    int err_total = 0;
    int num_checks = 0;
    always #25 ref_clk = ~ref_clk;
    // reject is a single-cycle pulse, so count it where it stands
    always @(posedge ref_clk) if (rej === 1'b1) rej_cnt <= rej_cnt + 1;
    dcsl_contact u_dcsl_contact (.closed(closed), .pin(pin));
    dcsl_top u_dcsl_top (.ref_clk(ref_clk), .rst_n(rst_n), .output_standby_pin(pin), .button_press(btn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .dc_output_on(on), .dc_locked(locked), .reject_error(rej), .irq(irq));
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 16) begin
            err_total++;
            results();
        end
    endtask
    task automatic cmd(input logic [1:0] c);
        wb(1'b1, dcsl_pkg::ADDR_CMD, {30'h0, c});
    endtask
    task automatic press;
        @(posedge ref_clk);
        btn <= 1'b1;
        @(posedge ref_clk);
        btn <= 1'b0;
    endtask
    // two sync stages plus the update edge, with margin
    task automatic pin_set(input logic c);
        @(posedge ref_clk);
        closed <= c;
        wait_n(6);
    endtask
    task automatic out_is(input logic o, input logic l);
        wait_n(2);
        chk({30'h0, on, locked}, {30'h0, o, l});
    endtask
    task automatic t_first;
        int r;
        chk({28'h0, on, locked, rej, irq}, 32'h0);
        wb(1'b1, dcsl_pkg::ADDR_IRQ_EN, 32'h7);
        wb(1'b1, dcsl_pkg::ADDR_CTRL, 32'hA);
        pin_set(1'b1);
        r = rej_cnt;
        cmd(2'h1);
        out_is(1'b0, 1'b1);
        chk(rej_cnt - r, 1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b0, dcsl_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rdat, 32'h1);
        wb(1'b1, dcsl_pkg::ADDR_IRQ_CLR, 32'h7);
        wb(1'b0, dcsl_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rdat | {31'h0, irq}, 32'h0);
        pin_set(1'b0);
        out_is(1'b0, 1'b0);
        wb(1'b0, 8'hFC, 32'h0);
        chk(rdat, 32'h0);
        $display("test first_on done");
    endtask
    task automatic t_toggle;
        cmd(2'h1);
        out_is(1'b1, 1'b0);
        cmd(2'h2);
        out_is(1'b0, 1'b0);
        press();
        out_is(1'b1, 1'b0);
        pin_set(1'b1);
        out_is(1'b0, 1'b1);
        wb(1'b0, dcsl_pkg::ADDR_STAT, 32'h0);
        chk(rdat, 32'h16);
        pin_set(1'b0);
        out_is(1'b1, 1'b0);
        wb(1'b0, dcsl_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rdat, 32'h6);
        wb(1'b1, dcsl_pkg::ADDR_IRQ_CLR, 32'h7);
        pin_set(1'b1);
        cmd(2'h2);
        pin_set(1'b0);
        out_is(1'b0, 1'b0);
        $display("test pin_toggle done");
    endtask
    task automatic t_modes;
        logic [3:0] cfg [2] = '{4'h2, 4'h8};
        foreach (cfg[i]) begin
            wb(1'b1, dcsl_pkg::ADDR_CTRL, {28'h0, cfg[i]});
            cmd(2'h1);
            out_is(1'b1, 1'b0);
            pin_set(1'b1);
            out_is(1'b0, 1'b1);
            pin_set(1'b0);
            out_is(1'b0, 1'b0);
        end
        $display("test rearm_remote done");
    endtask
    task automatic t_invert;
        int r;
        wb(1'b1, dcsl_pkg::ADDR_CTRL, 32'h1);
        pin_set(1'b1);
        cmd(2'h1);
        out_is(1'b1, 1'b0);
        pin_set(1'b0);
        out_is(1'b0, 1'b1);
        r = rej_cnt;
        press();
        out_is(1'b0, 1'b1);
        chk(rej_cnt - r, 1);
        $display("test invert done");
    endtask
    task automatic t_analog;
        wb(1'b1, dcsl_pkg::ADDR_CTRL, 32'h0);
        out_is(1'b0, 1'b0);
        wb(1'b1, dcsl_pkg::ADDR_CTRL, 32'hC);
        out_is(1'b1, 1'b0);
        wb(1'b0, dcsl_pkg::ADDR_CTRL, 32'h0);
        chk(rdat, 32'hC);
        pin_set(1'b1);
        out_is(1'b0, 1'b1);
        pin_set(1'b0);
        out_is(1'b1, 1'b0);
        $display("test analog done");
    endtask
    // reset in mid-run clears the first-on memory, so analog mode alone may not switch on
    task automatic t_reset;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        wait_n(5);
        rst_n <= 1'b1;
        wait_n(2);
        chk({28'h0, on, locked, rej, irq}, 32'h0);
        wb(1'b1, dcsl_pkg::ADDR_CTRL, 32'hC);
        out_is(1'b0, 1'b0);
        $display("test reset done");
    endtask
    initial begin
        wait_n(5);
        rst_n <= 1'b1;
        wait_n(2);
        t_first();
        t_toggle();
        t_modes();
        t_invert();
        t_analog();
        t_reset();
        results();
    end
endmodule
